// ==== pkg/adc_cfg_pkg.sv ====
// Register map, field layout and shared types of the converter configuration block.
package adc_cfg_pkg;

  localparam logic [7:0] ADDR_PORT_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_DEVICE_ID     = 8'h01;
  localparam logic [7:0] ADDR_SPEED_GRADE   = 8'h02;
  localparam logic [7:0] ADDR_POWER_MODE    = 8'h08;
  localparam logic [7:0] ADDR_OUTPUT_MODE   = 8'h14;
  localparam logic [7:0] ADDR_OVERRANGE_CFG = 8'h2a;
  localparam logic [7:0] ADDR_TRANSFER      = 8'hff;
  localparam logic [7:0] FUNC_FIRST         = 8'h08;
  localparam logic [7:0] FUNC_LAST          = 8'h2a;

  localparam logic [7:0] PORT_CONFIG_RESET   = 8'h18;
  localparam int         PORT_LSB_FIRST_HI   = 6;
  localparam int         PORT_LSB_FIRST_LO   = 1;
  localparam int         PORT_SOFT_RESET_HI  = 5;
  localparam int         PORT_SOFT_RESET_LO  = 2;
  localparam logic [7:0] POWER_MODE_RESET    = 8'h00;
  localparam logic [7:0] POWER_MODE_MASK     = 8'h27;
  localparam logic [7:0] OUTPUT_MODE_RESET   = 8'h00;
  localparam logic [7:0] OUTPUT_MODE_MASK    = 8'h1f;
  localparam logic [7:0] OVERRANGE_CFG_RESET = 8'h01;
  localparam logic [7:0] OVERRANGE_CFG_MASK  = 8'h01;
  localparam logic [7:0] TRANSFER_RESET      = 8'h00;
  localparam int         COMMIT_BIT          = 0;
  localparam int         POWERDOWN_PIN_RESPONSE_RESPONSE_BIT   = 5;
  localparam int         OUT_DISABLE_BIT     = 4;
  localparam int         OUT_INVERT_BIT      = 2;
  localparam int         OVR_ENABLE_BIT      = 0;
  localparam int         GRADE_LSB           = 3;

  localparam logic [2:0] PM_NORMAL     = 3'h0;
  localparam logic [2:0] PM_POWERDOWN  = 3'h1;
  localparam logic [2:0] PM_STANDBY    = 3'h2;
  localparam logic [2:0] PM_NORMAL_ALT = 3'h3;

  localparam int          INSTR_BITS  = 16;
  localparam int          BYTE_BITS   = 8;
  localparam logic [3:0]  INSTR_LAST  = 4'hf;
  localparam logic [2:0]  BYTE_LAST   = 3'h7;
  localparam int          RAW_BITS    = 14;
  localparam int          SAMPLE_BITS = 12;
  localparam logic signed [13:0] CODE_MAX = 14'sh07ff;
  localparam logic signed [13:0] CODE_MIN = 14'sh3800;
  localparam logic [11:0] MIDSCALE_FLIP   = 12'h0800;
  localparam logic [11:0] TC_POS_FULL     = 12'h07ff;
  localparam logic [11:0] TC_NEG_FULL     = 12'h0800;

  typedef enum logic [1:0] {
    FMT_OFFSET_BINARY,
    FMT_TWOS_COMPLEMENT,
    FMT_GRAY,
    FMT_RESERVED
  } format_type;

  typedef struct packed {
    logic [11:0] bits;
    logic        overrange;
  } sample_out_type;

  typedef struct packed {
    logic full_powerdown;
    logic standby;
  } power_status_type;

  typedef struct packed {
    logic [3:0]  bit_cnt;
    logic        data_phase;
    logic        is_read;
    logic [14:0] instr_shift;
    logic [7:0]  addr;
    logic [2:0]  byte_cnt;
    logic [6:0]  data_shift;
  } frame_state_type;

  typedef struct packed {
    logic       lsb_first;
    logic [7:0] power_mode_m;
    logic [7:0] output_mode_m;
    logic [7:0] overrange_cfg_m;
    logic       commit_toggle;
    logic       ack_meta;
    logic       ack_sync;
  } link_state_type;

  typedef struct packed {
    logic             commit_meta;
    logic             commit_sync;
    logic             commit_ack;
    logic             powerdown_pin_response_meta;
    logic             powerdown_pin_response_sync;
    logic [7:0]       power_mode_s;
    logic [7:0]       output_mode_s;
    logic [7:0]       overrange_cfg_s;
    sample_out_type   out;
    power_status_type pwr;
  } core_state_type;

endpackage

// ==== src/adc_config_regs.sv ====
// Serial configuration registers, shadow commit and sample output coder of the converter.
`timescale 1ns/100ps

// Functional notes
// - Offset binary: 000 at negative full scale, 800 at zero, FFF at positive.
// - Twos complement: 800 at negative full scale, 000 at zero, 7FF at positive.
// - Beyond full scale by over half an LSB: flag high, clamp code.
// - Regions: chip config 0x00-0x02, transfer 0xFF, functions 0x08-0x2A.
// - Function writes land in master copies; commit bit moves them to slaves.
// - Transfer register: bit 0 commits, other bits zero, default 0x00.
// - Reset loads listed defaults; registers without defaults keep contents.
// - Port config: bit order 6/1, soft reset 5/2, ones 4/3, default 0x18.
// - Identifier register is read-only eight bits; writes ignored.
// - Speed grade read-only in bits 4:3, bits 7:5 read zero.
// - Power mode 000/011 normal, 001 power-down, 010 standby; bit 5 pin response.
// - Frame: 16-bit instruction, first bit read or write, then data bytes.
// - Serial port shifts MSB first until bit order select is changed.
// - Format field: 00 offset binary, 01 twos complement, 10 Gray.
module adc_config_regs #(
  parameter logic [7:0] DEVICE_ID   = 8'h5c,
  parameter logic [1:0] SPEED_GRADE = 2'h0
) (
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  input  wire logic                           sclk,
  input  wire logic                           chip_select_n,
  input  wire logic                           sdio_in,
  output logic                                sdio_out,
  output logic                                sdio_oe_n,
  input  wire logic                           powerdown_pin,
  input  wire logic signed [13:0]             raw_code,
  output adc_cfg_pkg::sample_out_type         sample_out,
  output adc_cfg_pkg::power_status_type       power_status
);
  import adc_cfg_pkg::*;

  // The device identifier default above is arbitrary.

  frame_state_type frame_reg;
  frame_state_type frame_next;
  link_state_type  link_reg;
  link_state_type  link_next;
  core_state_type  core_reg;
  core_state_type  core_next;
  logic            frame_rst_n;
  logic            wr_strobe;
  logic [7:0]      wr_byte;
  logic [7:0]      msb_byte;
  logic [7:0]      rd_byte;
  logic            rd_bit;
  logic            sdio_out_reg;
  logic            sdio_oe_n_reg;

  // Frame logic is held clear while chip select is high, since the serial clock may stop.
  assign frame_rst_n = arst_n & ~chip_select_n;

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < BYTE_BITS; i++) begin
      r[i] = v[BYTE_BITS-1-i];
    end
    return r;
  endfunction

  function automatic logic [7:0] read_mux(input link_state_type l, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_PORT_CONFIG: begin
        v = PORT_CONFIG_RESET;
        v[PORT_LSB_FIRST_HI] = l.lsb_first;
        v[PORT_LSB_FIRST_LO] = l.lsb_first;
      end
      ADDR_DEVICE_ID:     v = DEVICE_ID;
      ADDR_SPEED_GRADE:   v = {3'h0, SPEED_GRADE, 3'h0};
      ADDR_POWER_MODE:    v = l.power_mode_m;
      ADDR_OUTPUT_MODE:   v = l.output_mode_m;
      ADDR_OVERRANGE_CFG: v = l.overrange_cfg_m;
      ADDR_TRANSFER: begin
        v = TRANSFER_RESET;
        v[COMMIT_BIT] = l.commit_toggle ^ l.ack_sync;
      end
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // Serial frame: instruction shift, then byte assembly.
  always_comb begin
    frame_next = frame_reg;
    wr_strobe  = 1'b0;
    msb_byte   = {frame_reg.data_shift, sdio_in};
    wr_byte    = link_reg.lsb_first ? reverse8(msb_byte) : msb_byte;
    if (!frame_reg.data_phase) begin
      frame_next.instr_shift = {frame_reg.instr_shift[13:0], sdio_in};
      frame_next.bit_cnt     = frame_reg.bit_cnt + 4'h1;
      if (frame_reg.bit_cnt == INSTR_LAST) begin
        frame_next.data_phase = 1'b1;
        frame_next.is_read    = frame_reg.instr_shift[INSTR_BITS-2];
        frame_next.addr       = {frame_reg.instr_shift[6:0], sdio_in};
        frame_next.byte_cnt   = 3'h0;
      end
    end else begin
      frame_next.data_shift = msb_byte[6:0];
      frame_next.byte_cnt   = frame_reg.byte_cnt + 3'h1;
      if (frame_reg.byte_cnt == BYTE_LAST) begin
        wr_strobe = ~frame_reg.is_read;
        // Streaming steps down in MSB-first mode and up in LSB-first mode.
        if (link_reg.lsb_first) begin
          frame_next.addr = frame_reg.addr + 8'h01;
        end else begin
          frame_next.addr = frame_reg.addr - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_reg <= '0;
    end else begin
      frame_reg <= frame_next;
    end
  end

  // Readback is launched on the falling edge so the host samples it on the next rise.
  always_comb begin
    rd_byte = read_mux(link_reg, frame_reg.addr);
    if (link_reg.lsb_first) begin
      rd_bit = rd_byte[frame_reg.byte_cnt];
    end else begin
      rd_bit = rd_byte[BYTE_LAST - frame_reg.byte_cnt];
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdio_out_reg  <= 1'b0;
      sdio_oe_n_reg <= 1'b1;
    end else begin
      sdio_out_reg  <= rd_bit;
      sdio_oe_n_reg <= ~(frame_reg.data_phase & frame_reg.is_read);
    end
  end

  assign sdio_out  = sdio_out_reg;
  assign sdio_oe_n = sdio_oe_n_reg;

  // Register writes on the serial clock.
  always_comb begin
    link_next          = link_reg;
    link_next.ack_meta = core_reg.commit_ack;
    link_next.ack_sync = link_reg.ack_meta;
    if (wr_strobe) begin
      unique case (frame_reg.addr)
        ADDR_PORT_CONFIG: begin
          if (wr_byte[PORT_SOFT_RESET_HI] | wr_byte[PORT_SOFT_RESET_LO]) begin
            // Soft reset restores the defaults and does not stay set.
            link_next.lsb_first       = 1'b0;
            link_next.power_mode_m    = POWER_MODE_RESET;
            link_next.output_mode_m   = OUTPUT_MODE_RESET;
            link_next.overrange_cfg_m = OVERRANGE_CFG_RESET;
          end else begin
            link_next.lsb_first = wr_byte[PORT_LSB_FIRST_HI] | wr_byte[PORT_LSB_FIRST_LO];
          end
        end
        ADDR_POWER_MODE:    link_next.power_mode_m    = wr_byte & POWER_MODE_MASK;
        ADDR_OUTPUT_MODE:   link_next.output_mode_m   = wr_byte & OUTPUT_MODE_MASK;
        ADDR_OVERRANGE_CFG: link_next.overrange_cfg_m = wr_byte & OVERRANGE_CFG_MASK;
        ADDR_TRANSFER: begin
          // A commit already in flight absorbs a second request.
          if (wr_byte[COMMIT_BIT] && (link_reg.commit_toggle == link_reg.ack_sync)) begin
            link_next.commit_toggle = ~link_reg.commit_toggle;
          end
        end
        // Identifier, grade and unmapped addresses ignore writes.
        default: link_next = link_next;
      endcase
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      link_reg                 <= '0;
      link_reg.power_mode_m    <= POWER_MODE_RESET;
      link_reg.output_mode_m   <= OUTPUT_MODE_RESET;
      link_reg.overrange_cfg_m <= OVERRANGE_CFG_RESET;
    end else begin
      link_reg <= link_next;
    end
  end

  // Converter clock domain: commit, power control and output coding.
  always_comb begin
    logic signed [13:0] clamped;
    logic               over;
    logic [11:0]        tc;
    logic [11:0]        ob;
    logic [11:0]        code;
    clamped = raw_code;
    over    = 1'b0;
    tc      = 12'h0000;
    ob      = 12'h0000;
    code    = 12'h0000;

    core_next             = core_reg;
    core_next.commit_meta = link_reg.commit_toggle;
    core_next.commit_sync = core_reg.commit_meta;
    core_next.powerdown_pin_response_meta   = powerdown_pin;
    core_next.powerdown_pin_response_sync   = core_reg.powerdown_pin_response_meta;

    // Master copies are quiet while the commit toggle travels, so a plain copy is safe.
    if (core_reg.commit_sync != core_reg.commit_ack) begin
      core_next.power_mode_s    = link_reg.power_mode_m;
      core_next.output_mode_s   = link_reg.output_mode_m;
      core_next.overrange_cfg_s = link_reg.overrange_cfg_m;
      core_next.commit_ack      = core_reg.commit_sync;
    end

    if (raw_code > CODE_MAX) begin
      clamped = CODE_MAX;
      over    = 1'b1;
    end else if (raw_code < CODE_MIN) begin
      clamped = CODE_MIN;
      over    = 1'b1;
    end
    tc = clamped[SAMPLE_BITS-1:0];
    ob = tc ^ MIDSCALE_FLIP;
    unique case (format_type'(core_reg.output_mode_s[1:0]))
      FMT_OFFSET_BINARY:   code = ob;
      FMT_TWOS_COMPLEMENT: code = tc;
      FMT_GRAY:            code = ob ^ (ob >> 1);
      FMT_RESERVED:        code = ob;
    endcase
    if (core_reg.output_mode_s[OUT_INVERT_BIT]) begin
      code = ~code;
    end
    if (core_reg.output_mode_s[OUT_DISABLE_BIT]) begin
      code = 12'h0000;
    end
    core_next.out.bits      = code;
    core_next.out.overrange = over & core_reg.overrange_cfg_s[OVR_ENABLE_BIT];

    // The pin overrides the register setting.
    if (core_reg.powerdown_pin_response_sync) begin
      core_next.pwr.standby        = core_reg.power_mode_s[POWERDOWN_PIN_RESPONSE_RESPONSE_BIT];
      core_next.pwr.full_powerdown = ~core_reg.power_mode_s[POWERDOWN_PIN_RESPONSE_RESPONSE_BIT];
    end else begin
      unique case (core_reg.power_mode_s[2:0])
        PM_POWERDOWN: core_next.pwr = '{full_powerdown: 1'b1, standby: 1'b0};
        PM_STANDBY:   core_next.pwr = '{full_powerdown: 1'b0, standby: 1'b1};
        default:      core_next.pwr = '{full_powerdown: 1'b0, standby: 1'b0};
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_reg                 <= '0;
      core_reg.power_mode_s    <= POWER_MODE_RESET;
      core_reg.output_mode_s   <= OUTPUT_MODE_RESET;
      core_reg.overrange_cfg_s <= OVERRANGE_CFG_RESET;
      core_reg.out.bits        <= MIDSCALE_FLIP;
    end else begin
      core_reg <= core_next;
    end
  end

  assign sample_out   = core_reg.out;
  assign power_status = core_reg.pwr;

endmodule

// ==== verification/adc_config_regs_monitor.sv ====
// Port-level assertions for the converter configuration block.
`timescale 1ns/100ps
module adc_config_regs_monitor (
  input logic                          clk,
  input logic                          arst_n,
  input logic                          sclk,
  input logic                          chip_select_n,
  input logic                          sdio_in,
  input logic                          sdio_out,
  input logic                          sdio_oe_n,
  input logic                          powerdown_pin,
  input logic signed [13:0]            raw_code,
  input adc_cfg_pkg::sample_out_type   sample_out,
  input adc_cfg_pkg::power_status_type power_status
);
  import adc_cfg_pkg::*;
  logic [4:0] rise_cnt;
  logic       rd_frame;
  // Chip select high clears the count, just as it clears the frame logic.
  always_ff @(posedge sclk or posedge chip_select_n or negedge arst_n) begin
    if (!arst_n || chip_select_n) begin
      rise_cnt <= 5'h00;
      rd_frame <= 1'b0;
    end else begin
      if (rise_cnt == 5'h00) begin
        rd_frame <= sdio_in;
      end
      if (rise_cnt != 5'h11) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end
  property p_ovr_cause;
    @(posedge clk) disable iff (!arst_n)
      sample_out.overrange |-> ($past(raw_code) > CODE_MAX || $past(raw_code) < CODE_MIN);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause)
    else $error("overrange flag without out-of-range input");
  property p_ovr_low;
    @(posedge clk) disable iff (!arst_n)
      (raw_code <= CODE_MAX && raw_code >= CODE_MIN) |=> !sample_out.overrange;
  endproperty
  a_ovr_low: assert property (p_ovr_low)
    else $error("overrange flag raised for in-range input");
  property p_clamp;
    @(posedge clk) disable iff (!arst_n)
      sample_out.overrange |-> sample_out.bits inside {12'h000, 12'hfff, 12'h800, 12'h7ff};
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("overrange word not clamped to full scale");
  property p_pd_pin;
    @(posedge clk) disable iff (!arst_n)
      powerdown_pin [*4] |=> (power_status.full_powerdown || power_status.standby);
  endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("power-down pin ignored");
  property p_pwr_excl;
    @(posedge clk) disable iff (!arst_n)
      !(power_status.full_powerdown && power_status.standby);
  endproperty
  a_pwr_excl: assert property (p_pwr_excl)
    else $error("full power-down and standby both set");
  property p_oe_idle;
    @(posedge clk) disable iff (!arst_n)
      chip_select_n [*2] |-> sdio_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data line driven outside a frame");
  property p_oe_instr;
    @(posedge sclk) disable iff (!arst_n || chip_select_n)
      rise_cnt < 5'h10 |-> sdio_oe_n;
  endproperty
  a_oe_instr: assert property (p_oe_instr)
    else $error("data line driven during instruction phase");
  property p_oe_read;
    @(posedge sclk) disable iff (!arst_n || chip_select_n)
      rise_cnt >= 5'h10 |-> (sdio_oe_n == !rd_frame);
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("data line direction does not follow read bit");
endmodule

bind adc_config_regs adc_config_regs_monitor adc_config_regs_monitor_i (
  .clk(clk), .arst_n(arst_n), .sclk(sclk), .chip_select_n(chip_select_n),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
  .powerdown_pin(powerdown_pin), .raw_code(raw_code), .sample_out(sample_out),
  .power_status(power_status)
);

// ==== verification/serial_host_model.sv ====
// Host controller model driving the three-wire serial port.
`timescale 1ns/100ps
module serial_host_model (
  output logic sclk,
  output logic chip_select_n,
  output logic sdio_in,
  input  logic sdio_out,
  input  logic sdio_oe_n
);
  logic host_bit;
  logic host_en;
  // A released line shows the inverse of the last bit, so stale data never passes as a read.
  assign sdio_in = !sdio_oe_n ? sdio_out : (host_en ? host_bit : !host_bit);
  // Chip select starts low for a moment, so the frame reset sees a clean edge when reset falls.
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b0;
    host_bit = 1'b0;
    host_en = 1'b0;
    #2;
    chip_select_n = 1'b1;
  end
  // The serial clock only runs inside a frame.
  task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wdat,
                      input logic lsb, output logic [7:0] rdat);
    logic [23:0] frame;
    logic [7:0]  wbyte;
    wbyte = wdat;
    if (lsb) begin
      wbyte = {<<{wdat}};
    end
    frame = {rd, 7'h00, addr, wbyte};
    rdat = 8'h00;
    #3.3;
    chip_select_n = 1'b0;
    host_en = 1'b1;
    for (int i = 0; i < 24; i++) begin
      host_bit = frame[23 - i];
      if (rd && i > 15) begin
        host_en = 1'b0;
      end
      #7.5 sclk = 1'b1;
      if (i > 15) begin
        rdat = {rdat[6:0], sdio_in};
      end
      #7.5 sclk = 1'b0;
    end
    #7.5 chip_select_n = 1'b1;
    host_en = 1'b0;
    if (lsb) begin
      rdat = {<<{rdat}};
    end
  endtask
endmodule

// ==== verification/tb_adc_config_regs.sv ====
// Self-checking testbench of the converter configuration block.
`timescale 1ns/100ps
module tb_adc_config_regs;
  import adc_cfg_pkg::*;
  localparam logic [7:0] ID_CODE = 8'h35; // Arbitrary identifier value.
  localparam logic [1:0] GRADE   = 2'h2;
  typedef struct packed { logic signed [13:0] raw; logic [12:0] exp; } row_type;
  logic clk, arst_n, sclk, chip_select_n, sdio_in, sdio_out, sdio_oe_n, powerdown_pin;
  logic signed [13:0] raw_code;
  sample_out_type     sample_out;
  power_status_type   power_status;
  logic [7:0]         rd_val;
  logic               lsb_mode;
  int                 err_total;
  int                 n_tests;
  row_type rows [7] = '{'{14'sh0000, 13'h0800}, '{14'sh3800, 13'h0000},
    '{14'sh07ff, 13'h0fff}, '{14'sh0800, 13'h1fff}, '{14'sh37ff, 13'h1000},
    '{14'sh0064, 13'h0864}, '{14'sh3fff, 13'h07ff}};
  logic [7:0] pm_val [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
  logic [1:0] pm_exp [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  adc_config_regs #(.DEVICE_ID(ID_CODE), .SPEED_GRADE(GRADE)) adc_config_regs_i (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .powerdown_pin(powerdown_pin), .raw_code(raw_code), .sample_out(sample_out),
    .power_status(power_status));
  serial_host_model serial_host_model_i (.sclk(sclk), .chip_select_n(chip_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic r, input logic [7:0] a, input logic [7:0] d);
    serial_host_model_i.xfer(r, a, d, lsb_mode, rd_val);
    @(negedge clk);
  endtask
  // Function values only take effect once the commit bit is written.
  task automatic commit;
    rw(1'b0, 8'hff, 8'h01);
    repeat (12) @(negedge clk);
  endtask
  task automatic run_rows(input logic [1:0] fmt);
    logic [11:0] ob;
    for (int i = 0; i < 7; i++) begin
      raw_code = rows[i].raw;
      @(negedge clk);
      ob = rows[i].exp[11:0];
      if (fmt == 2'h1) begin
        ob = ob ^ 12'h800;
      end
      if (fmt == 2'h2) begin
        ob = ob ^ {1'b0, ob[11:1]};
      end
      chk({3'h0, sample_out.overrange, sample_out.bits}, {3'h0, rows[i].exp[12], ob});
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    arst_n = 1'b1;
    powerdown_pin = 1'b0;
    raw_code = 14'sh0000;
    lsb_mode = 1'b0;
    err_total = 0;
    n_tests = 0;
    // Reset falls after time zero so every asynchronous reset sees a real edge.
    #1;
    arst_n = 1'b0;
    repeat (10) @(negedge clk);
    chk({3'h0, sample_out}, 16'h1000);
    arst_n = 1'b1;
    run_rows(2'h0);
    rw(1'b0, 8'h14, 8'h01);
    run_rows(2'h0);
    commit();
    run_rows(2'h1);
    rw(1'b1, 8'hff, 8'h00);
    rw(1'b1, 8'hff, 8'h00);
    chk({8'h00, rd_val}, 16'h0000);
    rw(1'b0, 8'h14, 8'h02);
    commit();
    run_rows(2'h2);
    rw(1'b0, 8'h14, 8'h04);
    commit();
    raw_code = 14'sh0064;
    @(negedge clk);
    chk({3'h0, sample_out.overrange, sample_out.bits}, 16'h079b);
    rw(1'b0, 8'h14, 8'h10);
    commit();
    raw_code = 14'sh0800;
    @(negedge clk);
    chk({3'h0, sample_out.overrange, sample_out.bits}, 16'h1000);
    rw(1'b0, 8'h2a, 8'h00);
    commit();
    chk({3'h0, sample_out.overrange, sample_out.bits}, 16'h0000);
    rw(1'b0, 8'h01, 8'h00);
    rw(1'b1, 8'h01, 8'h00);
    chk({8'h00, rd_val}, {8'h00, ID_CODE});
    rw(1'b1, 8'h02, 8'h00);
    chk({8'h00, rd_val & 8'hf8}, {11'h000, GRADE, 3'h0});
    rw(1'b1, 8'h30, 8'h00);
    chk({8'h00, rd_val}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, 8'h08, pm_val[i]);
      commit();
      chk({14'h0000, power_status}, {14'h0000, pm_exp[i]});
    end
    powerdown_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk({14'h0000, power_status}, 16'h0002);
    rw(1'b0, 8'h08, 8'h20);
    commit();
    chk({14'h0000, power_status}, 16'h0001);
    powerdown_pin = 1'b0;
    rw(1'b0, 8'h00, 8'h5a);
    lsb_mode = 1'b1;
    rw(1'b1, 8'h01, 8'h00);
    chk({8'h00, rd_val}, {8'h00, ID_CODE});
    rw(1'b1, 8'h00, 8'h00);
    chk({8'h00, rd_val}, 16'h005a);
    rw(1'b0, 8'h00, 8'h3c);
    lsb_mode = 1'b0;
    rw(1'b1, 8'h00, 8'h00);
    chk({8'h00, rd_val}, 16'h0018);
    rw(1'b0, 8'h14, 8'h01);
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    rw(1'b1, 8'h14, 8'h00);
    chk({8'h00, rd_val}, 16'h0000);
    rw(1'b1, 8'h08, 8'h00);
    chk({8'h00, rd_val}, 16'h0000);
    chk({14'h0000, power_status}, 16'h0000);
    run_rows(2'h0);
    summarize();
  end
endmodule
